// *** spm_pkg.sv ***
// Constants, field positions and types for the serial peripheral port
package spm_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [31:0] SPM_CTRL_ADDR = 32'h1590_0000;
    localparam logic [31:0] SPM_STAT_ADDR = 32'h1590_0004;
    localparam logic [31:0] SPM_PIN_ADDR = 32'h1590_0008;
    localparam logic [31:0] SPM_PRE_ADDR = 32'h1590_000C;
    localparam logic [31:0] SPM_TX_ADDR = 32'h1590_0010;
    localparam logic [31:0] SPM_RX_ADDR = 32'h1590_0014;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SPM_CTRL_RST = 8'h00;
    localparam logic [7:0] SPM_STAT_RST = 8'h01;
    localparam logic [7:0] SPM_PIN_RST = 8'h02;
    localparam logic [7:0] SPM_PRE_RST = 8'h00;
    localparam logic [7:0] SPM_TX_RST = 8'h00;
    localparam logic [7:0] SPM_RX_RST = 8'h00;

    // ==========================================================
    // Control register fields
    localparam int SPM_CTRL_EN = 7;
    localparam int SPM_CTRL_MODE_HI = 6;
    localparam int SPM_CTRL_MODE_LO = 5;
    localparam int SPM_CTRL_GATE = 4;
    localparam int SPM_CTRL_MASTER_SELECT = 3;
    localparam int SPM_CTRL_CLOCK_POLARITY = 2;
    localparam int SPM_CTRL_CLOCK_PHASE = 1;
    localparam int SPM_CTRL_ADUM = 0;

    // ==========================================================
    // Status and pin control fields
    localparam int SPM_STAT_COL = 2;
    localparam int SPM_STAT_MMF = 1;
    localparam int SPM_STAT_RDY = 0;
    localparam int SPM_PIN_MMDE = 2;
    localparam int SPM_PIN_CS = 1;
    localparam int SPM_PIN_KEEP = 0;

    // ==========================================================
    // Transfer constants
    localparam logic [7:0] SPM_DUMMY_BYTE = 8'hFF;
    localparam logic [3:0] SPM_LAST_EDGE = 4'hF;
    localparam logic [2:0] SPM_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        SPM_MODE_POLL = 2'b00,
        SPM_MODE_IRQ = 2'b01,
        SPM_MODE_DMA = 2'b10,
        SPM_MODE_RSVD = 2'b11
    } spm_mode_t;

endpackage : spm_pkg

// *** spm_port.sv ***
// Byte-wide master/slave serial peripheral port with register and DMA access
`timescale 1ns/100ps
// How it works
// - Mode field picks polling, interrupt or DMA service; code 11 is unused.
// - Prescaler gate enables divided serial clock, master mode only.
// - Master select bit: 0 slave on external clock, 1 master driving clock.
// - Polarity bit: 0 idles clock low, 1 idles clock high.
// - Phase bit picks format A or B for launch and sample edges.
// - Auto-dummy: reading received byte starts a 0xFF transfer.
// - Write or read of data during a transfer sets collision flag; status read clears.
// - Master with detection on: select going low sets multi-master flag.
// - Ready flag resets high, clears on transmit write, sets at byte end.
// - When enabled, clock and data pin directions follow master select.
// - As slave, select pin is always an input.
// - Detection on in master mode makes select pin a monitored input.
// - Master drives select pin from card select bit unless detection on.
// - Keep bit: 0 releases master out line after a byte, 1 holds it.
// - Master drives out and clock, samples in; slave does the reverse.
// - Multi-master error clears master select, sets flag, raises interrupt.
// - Serial clock is bus clock divided by two, and with the gate set also by prescaler plus one.
// - DMA transmit: request, take one byte, shift it out, repeat.
// - DMA receive with auto-dummy: request per byte, then send 0xFF.
// - Transmit write while enabled as master starts an eight-bit exchange.
// - Each completed byte lands in the read-only receive register.
module spm_port
    import spm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // DMA channel
    output logic dma_req,
    input wire logic dma_ack,
    input wire logic [7:0] dma_wdata,
    output logic [7:0] dma_rdata,
    // Interrupt
    output logic spi_irq,
    // Serial clock pin
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    // Master out pin
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    // Master in pin
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    // Slave select pin
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe
);

    // ==========================================================
    // State
    logic [7:0] ctrl_q;
    logic [2:0] pin_q;
    logic [7:0] pre_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] sh_q;
    logic [7:0] rxsh_q;
    logic [7:0] div_q;
    logic [3:0] edge_q;
    logic [2:0] bits_q;
    logic [31:0] rdata_q;
    logic col_q;
    logic mmf_q;
    logic rdy_q;
    logic busy_q;
    logic sck_q;
    logic out_q;
    logic irq_q;
    logic sck_prev_q;
    logic ss_prev_q;

    // ==========================================================
    // Decode and configuration
    logic en;
    logic master;
    logic clock_polarity;
    logic clock_phase;
    logic adum;
    logic mmde;
    spm_mode_t mode;
    logic wr_ctrl;
    logic wr_pin;
    logic wr_pre;
    logic wr_tx;
    logic rd_rx;
    logic rd_stat;
    logic dma_take;
    logic load_req;
    logic [7:0] load_data;
    logic start;
    logic mm_err;
    logic tick;
    logic m_lead;
    logic m_trail;
    logic selected;
    logic s_lead;
    logic s_trail;
    logic s_begin;
    logic active;
    logic lead;
    logic trail;
    logic sample;
    logic launch;
    logic din;
    logic done;
    logic [7:0] rx_next;

    assign en = ctrl_q[SPM_CTRL_EN];
    assign master = ctrl_q[SPM_CTRL_MASTER_SELECT];
    assign clock_polarity = ctrl_q[SPM_CTRL_CLOCK_POLARITY];
    assign clock_phase = ctrl_q[SPM_CTRL_CLOCK_PHASE];
    assign adum = ctrl_q[SPM_CTRL_ADUM];
    assign mode = spm_mode_t'(ctrl_q[SPM_CTRL_MODE_HI:SPM_CTRL_MODE_LO]);
    assign mmde = pin_q[SPM_PIN_MMDE];

    assign wr_ctrl = reg_wr && (reg_addr == SPM_CTRL_ADDR);
    assign wr_pin = reg_wr && (reg_addr == SPM_PIN_ADDR);
    assign wr_pre = reg_wr && (reg_addr == SPM_PRE_ADDR);
    assign wr_tx = reg_wr && (reg_addr == SPM_TX_ADDR);
    assign rd_rx = reg_rd && (reg_addr == SPM_RX_ADDR);
    assign rd_stat = reg_rd && (reg_addr == SPM_STAT_ADDR);
    assign dma_take = dma_ack && (mode == SPM_MODE_DMA);

    // ==========================================================
    // Transfer launch requests
    assign load_req = !busy_q && (wr_tx || (adum && rd_rx) || dma_take);
    assign load_data = wr_tx ? reg_wdata[7:0] : (adum ? SPM_DUMMY_BYTE : dma_wdata);
    assign start = load_req && en && master;
    assign mm_err = en && master && mmde && ss_prev_q && !ss_n_i;

    // ==========================================================
    // Edge generation, master and slave
    assign tick = busy_q && master && (!ctrl_q[SPM_CTRL_GATE] || (div_q == pre_q));
    assign m_lead = tick && !edge_q[0];
    assign m_trail = tick && edge_q[0];
    assign selected = en && !master && !ss_n_i;
    assign s_lead = selected && (sck_prev_q == clock_polarity) && (sck_i != clock_polarity);
    assign s_trail = selected && (sck_prev_q != clock_polarity) && (sck_i == clock_polarity);
    assign s_begin = s_lead && !busy_q;
    assign active = busy_q || s_begin;
    assign lead = master ? m_lead : (s_lead && active);
    assign trail = master ? m_trail : (s_trail && active);
    assign sample = clock_phase ? trail : lead;
    assign launch = clock_phase ? lead : (trail && !(master && edge_q == SPM_LAST_EDGE));
    assign din = master ? miso_i : mosi_i;
    assign rx_next = sample ? {rxsh_q[6:0], din} : rxsh_q;
    assign done = master ? (m_trail && edge_q == SPM_LAST_EDGE)
                         : (sample && active && bits_q == SPM_LAST_BIT);

    // ==========================================================
    // Control register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= SPM_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[7:0];
            end
            if (mm_err) begin
                ctrl_q[SPM_CTRL_MASTER_SELECT] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Pin control and prescaler registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= SPM_PIN_RST[2:0];
            pre_q <= SPM_PRE_RST;
        end else begin
            if (wr_pin) begin
                pin_q <= reg_wdata[2:0];
            end
            if (wr_pre) begin
                pre_q <= reg_wdata[7:0];
            end
        end
    end

    // ==========================================================
    // Status flags, set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= SPM_STAT_RST[SPM_STAT_COL];
            mmf_q <= SPM_STAT_RST[SPM_STAT_MMF];
            rdy_q <= SPM_STAT_RST[SPM_STAT_RDY];
        end else begin
            if (busy_q && (wr_tx || rd_rx)) begin
                col_q <= 1'b1;
            end else if (rd_stat) begin
                col_q <= 1'b0;
            end
            if (mm_err) begin
                mmf_q <= 1'b1;
            end else if (rd_stat) begin
                mmf_q <= 1'b0;
            end
            if (done) begin
                rdy_q <= 1'b1;
            end else if (load_req) begin
                rdy_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Transfer activity and counters
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            edge_q <= 4'h0;
            bits_q <= 3'h0;
            div_q <= 8'h00;
        end else begin
            if (start || s_begin) begin
                busy_q <= 1'b1;
            end else if (done || mm_err || !en || (!master && ss_n_i)) begin
                busy_q <= 1'b0;
            end
            if (start) begin
                edge_q <= 4'h0;
            end else if (tick) begin
                edge_q <= edge_q + 4'h1;
            end
            if (start) begin
                bits_q <= 3'h0;
            end else if (s_begin) begin
                bits_q <= sample ? 3'h1 : 3'h0;
            end else if (sample && active) begin
                bits_q <= bits_q + 3'h1;
            end
            if (!busy_q || tick) begin
                div_q <= 8'h00;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // ==========================================================
    // Shift registers and serial clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= 8'h00;
            rxsh_q <= 8'h00;
            out_q <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            if (load_req) begin
                if (!clock_phase) begin
                    out_q <= load_data[7];
                    sh_q <= {load_data[6:0], 1'b0};
                end else begin
                    sh_q <= load_data;
                end
            end else if (launch && active) begin
                out_q <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
            end
            if (active) begin
                rxsh_q <= rx_next;
            end
            if (busy_q && master) begin
                sck_q <= tick ? !sck_q : sck_q;
            end else begin
                sck_q <= clock_polarity;
            end
        end
    end

    // ==========================================================
    // Data registers and interrupt
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= SPM_TX_RST;
            rx_q <= SPM_RX_RST;
            irq_q <= 1'b0;
        end else begin
            if (load_req) begin
                tx_q <= load_data;
            end
            if (done) begin
                rx_q <= rx_next;
            end
            irq_q <= (done && mode == SPM_MODE_IRQ) || mm_err;
        end
    end

    // ==========================================================
    // Register read port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SPM_CTRL_ADDR: rdata_q <= {24'h00_0000, ctrl_q};
                SPM_STAT_ADDR: rdata_q <= {29'h0000_0000, col_q, mmf_q, rdy_q};
                SPM_PIN_ADDR: rdata_q <= {29'h0000_0000, pin_q};
                SPM_PRE_ADDR: rdata_q <= {24'h00_0000, pre_q};
                SPM_TX_ADDR: rdata_q <= {24'h00_0000, tx_q};
                SPM_RX_ADDR: rdata_q <= {24'h00_0000, rx_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Edge history of pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_i;
            ss_prev_q <= ss_n_i;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_q;
    assign dma_req = en && (mode == SPM_MODE_DMA) && rdy_q && !busy_q;
    assign dma_rdata = rx_q;
    assign spi_irq = irq_q;
    assign sck_o = sck_q;
    assign sck_oe = en && master;
    assign mosi_o = out_q;
    assign mosi_oe = en && master && (busy_q || pin_q[SPM_PIN_KEEP]);
    assign miso_o = out_q;
    assign miso_oe = en && !master && !ss_n_i;
    assign ss_n_o = pin_q[SPM_PIN_CS];
    assign ss_n_oe = master && !mmde;

endmodule : spm_port

// *** spm_port_assertions.sv ***
// Port assertions for the serial peripheral port
`timescale 1ns/100ps
module spm_port_checker
    import spm_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // DMA, interrupt and pins
    input wire logic dma_req,
    input wire logic dma_ack,
    input wire logic spi_irq,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_i,
    input wire logic ss_n_oe
);
    // ====
    // Sequences
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_tx_go;
        reg_wr && reg_addr == SPM_TX_ADDR && sck_oe;
    endsequence
    sequence s_stat_rd;
        reg_rd && reg_addr == SPM_STAT_ADDR;
    endsequence
    sequence s_mm_fall;
        sck_oe && !ss_n_oe ##1 $fell(ss_n_i);
    endsequence
    // ====
    // Assertions
    a_pin_roles: assert property (!(sck_oe && miso_oe))
        else $error("clock and slave data driven together");
    a_mosi_master: assert property (mosi_oe |-> sck_oe)
        else $error("master out driven outside master role");
    a_slave_select: assert property (miso_oe |-> !ss_n_i && !ss_n_oe)
        else $error("slave data driven while not selected");
    a_irq_pulse: assert property (spi_irq |=> !spi_irq)
        else $error("interrupt longer than one cycle");
    a_mm_demote: assert property (s_mm_fall |-> ##[1:2] (!sck_oe && spi_irq))
        else $error("multi-master error did not demote");
    a_dma_drop: assert property (dma_req && dma_ack |=> !dma_req)
        else $error("request stayed after acknowledge");
    a_rdy_clear: assert property (s_tx_go ##2 s_stat_rd |=> !reg_rdata[SPM_STAT_RDY])
        else $error("ready still set after transmit write");
    a_col_flag: assert property (s_tx_go ##2 s_tx_go ##2 s_stat_rd |=> reg_rdata[2])
        else $error("collision not flagged");
endmodule : spm_port_checker
bind spm_port spm_port_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_req(dma_req), .dma_ack(dma_ack), .spi_irq(spi_irq), .sck_oe(sck_oe),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_i(ss_n_i), .ss_n_oe(ss_n_oe));

// *** spm_card.sv ***
// Behavioural serial card on the far side of the port
`timescale 1ns/100ps
module spm_card (
    // Link pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // Setup and capture
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    int cnt = 0;
    initial rx_byte = 8'h00;
    initial miso = 1'b0;
    always @(negedge ss_n) begin
        cnt = 0;
        miso = tx_byte[7];
    end
    // Released line shows the inverse of its last level
    always @(posedge ss_n) miso = ~miso;
    // Sample on one edge, present the next bit on the other
    always @(sck) begin
        if (!ss_n && ((sck !== clock_polarity) != clock_phase)) begin
            rx_byte = {rx_byte[6:0], mosi};
        end else if (!ss_n) begin
            miso = tx_byte[7 - ((cnt + int'(!clock_phase)) % 8)];
            cnt = cnt + 1;
        end
    end
endmodule : spm_card

// *** spm_port_tb.sv ***
// Self-checking bench for the serial peripheral port
`timescale 1ns/100ps
module spm_port_tb
    import spm_pkg::*;
;
    logic clk_sys, rst_n, reg_wr, reg_rd, dma_req, dma_ack, spi_irq, tb_ss, card_clock_polarity, card_clock_phase;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] dma_wdata, dma_rdata, card_rx;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, card_miso;
    wire logic sck_w = sck_oe ? sck_o : card_clock_polarity;
    wire logic mosi_w = mosi_oe ? mosi_o : 1'b1;
    wire logic miso_w = miso_oe ? miso_o : card_miso;
    wire logic ss_w = ss_n_oe ? ss_n_o : tb_ss;
    int errors = 0;
    int n_checks = 0;
    int n_irq = 0;
    spm_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dma_req(dma_req), .dma_ack(dma_ack), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
        .spi_irq(spi_irq), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
    spm_card card (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .miso(card_miso),
        .clock_polarity(card_clock_polarity), .clock_phase(card_clock_phase), .tx_byte(8'h96), .rx_byte(card_rx));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) n_irq <= n_irq + int'(spi_irq === 1'b1);
    // ====
    // Bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= {24'h000000, d};
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rdc
    task automatic ack(input logic [7:0] d);
        @(posedge clk_sys);
        dma_ack <= 1'b1;
        dma_wdata <= d;
        @(posedge clk_sys);
        dma_ack <= 1'b0;
        #1;
    endtask : ack
    task automatic wait_rdy;
        logic [31:0] d;
        d = 32'h0;
        for (int i = 0; i < 200 && d[0] !== 1'b1; i++) begin
            rd(SPM_STAT_ADDR, d);
        end
        chk(d, 32'h1);
    endtask : wait_rdy
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // ====
    // Scenarios
    task automatic t_reset;
        logic [31:0] a[7];
        a = '{SPM_CTRL_ADDR, SPM_STAT_ADDR, SPM_PIN_ADDR, SPM_PRE_ADDR, SPM_TX_ADDR,
            SPM_RX_ADDR, 32'h1590_0018};
        wr(SPM_STAT_ADDR, 8'hFE);
        wr(32'h1590_0018, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rdc(a[i], (i == 1) ? 32'h1 : (i == 2) ? 32'h2 : 32'h0);
        end
    endtask : t_reset
    task automatic t_xfer;
        wr(SPM_CTRL_ADDR, 8'h98);
        wr(SPM_PIN_ADDR, 8'h00);
        wr(SPM_TX_ADDR, 8'hA5);
        wr(SPM_TX_ADDR, 8'h11);
        rdc(SPM_STAT_ADDR, 32'h4);
        wait_rdy();
        rdc(SPM_RX_ADDR, 32'h96);
        chk(32'(card_rx), 32'hA5);
        chk(32'({mosi_oe, ss_n_oe, ss_n_o, sck_oe, miso_oe}), 32'hA);
        chk(32'(n_irq), 32'h0);
    endtask : t_xfer
    task automatic t_speed;
        int n;
        wr(SPM_PIN_ADDR, 8'h01);
        for (int p = 1; p < 4; p += 2) begin
            wr(SPM_PRE_ADDR, 8'(p));
            wr(SPM_TX_ADDR, 8'h80);
            @(posedge sck_o);
            n = 0;
            while (sck_o === 1'b1 && n < 20) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk(32'(n), 32'(p + 1));
            wait_rdy();
        end
        wr(SPM_CTRL_ADDR, 8'h88);
        wr(SPM_TX_ADDR, 8'h80);
        @(posedge sck_o);
        @(posedge clk_sys);
        #1;
        chk(32'(sck_o), 32'h0);
        wait_rdy();
        chk(32'({mosi_oe, mosi_o}), 32'h2);
    endtask : t_speed
    task automatic t_auto;
        wr(SPM_CTRL_ADDR, 8'hB9);
        rdc(SPM_RX_ADDR, 32'h96);
        wait_rdy();
        chk(32'(card_rx), 32'hFF);
        chk(32'(n_irq), 32'h1);
    endtask : t_auto
    task automatic t_dma;
        wr(SPM_CTRL_ADDR, 8'hD8);
        chk(32'(dma_req), 32'h1);
        ack(8'h5A);
        chk(32'(dma_req), 32'h0);
        wait_rdy();
        chk(32'({card_rx, dma_rdata}), 32'h5A96);
        wr(SPM_CTRL_ADDR, 8'hD9);
        ack(8'h00);
        wait_rdy();
        chk(32'({card_rx, 8'(n_irq)}), 32'hFF01);
        wr(SPM_CTRL_ADDR, 8'h98);
        rdc(SPM_RX_ADDR, 32'h96);
        rdc(SPM_STAT_ADDR, 32'h1);
    endtask : t_dma
    task automatic t_clock_polarity;
        wr(SPM_PIN_ADDR, 8'h02);
        wr(SPM_CTRL_ADDR, 8'h9C);
        card_clock_polarity <= 1'b1;
        wr(SPM_PIN_ADDR, 8'h00);
        chk(32'({sck_oe, sck_o}), 32'h3);
        wr(SPM_TX_ADDR, 8'hC3);
        wait_rdy();
        rdc(SPM_RX_ADDR, 32'h96);
        chk(32'(card_rx), 32'hC3);
        wr(SPM_PIN_ADDR, 8'h01);
        wr(SPM_CTRL_ADDR, 8'h9E);
        card_clock_phase <= 1'b1;
        wr(SPM_TX_ADDR, 8'h3C);
        wait_rdy();
        rdc(SPM_RX_ADDR, 32'h96);
        chk(32'(card_rx), 32'h3C);
    endtask : t_clock_polarity
    task automatic t_mm;
        card_clock_polarity <= 1'b0;
        wr(SPM_PIN_ADDR, 8'h04);
        wr(SPM_CTRL_ADDR, 8'h98);
        @(posedge clk_sys);
        tb_ss <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(32'({sck_oe, miso_oe, ss_n_oe}), 32'h2);
        rdc(SPM_STAT_ADDR, 32'h3);
        rdc(SPM_CTRL_ADDR, 32'h90);
        chk(32'(n_irq), 32'h2);
    endtask : t_mm
    task automatic t_slave;
        logic [7:0] got;
        got = 8'h00;
        wr(SPM_TX_ADDR, 8'h5C);
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            got = {got[6:0], miso_w};
            card_clock_polarity <= 1'b1;
            repeat (2) @(posedge clk_sys);
            card_clock_polarity <= 1'b0;
            @(posedge clk_sys);
        end
        chk(32'(got), 32'h5C);
        rdc(SPM_STAT_ADDR, 32'h1);
        rdc(SPM_RX_ADDR, 32'hFF);
    endtask : t_slave
    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, dma_ack, card_clock_polarity, card_clock_phase} = 5'h00;
        {reg_addr, reg_wdata, dma_wdata} = 72'h0;
        tb_ss = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_xfer();
        t_speed();
        t_auto();
        t_dma();
        t_clock_polarity();
        t_mm();
        t_slave();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        close_out();
    end
endmodule : spm_port_tb
